// ### rmcg_pkg.sv
/*
 Package for the run-mode clock gating block: register offsets, field positions,
 reset values and encodings. Assumes a 32-bit AHB-Lite register bus.
*/
package rmcg_pkg;
	// Register byte offsets
	localparam logic [11:0] RUN_GATE_OFF = 12'h0100;
	localparam logic [11:0] SLEEP_GATE_OFF = 12'h0110;
	localparam logic [11:0] DEEP_GATE_OFF = 12'h0120;
	localparam logic [11:0] RUN_CONFIG_OFF = 12'h0060;
	// Field positions
	localparam int CAN_BIT = 24;
	localparam int SAMPLER_BIT = 16;
	localparam int RATE_LSB = 8;
	localparam int RATE_MSB = 9;
	localparam int KEEPER_BIT = 6;
	localparam int WDOG_BIT = 3;
	localparam int AUTO_GATE_BIT = 27;
	// Writable bits and reset values of the gating registers and the run config register
	localparam logic [31:0] GATE_WMASK = 32'h0101_0348;
	localparam logic [31:0] GATE_RESET = 32'h0000_0040;
	localparam logic [31:0] CONFIG_WMASK = 32'h0800_0000;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	// Sample-rate field encodings
	localparam logic [1:0] RATE_125K = 2'h0;
	localparam logic [1:0] RATE_250K = 2'h1;
	localparam logic [1:0] RATE_500K = 2'h2;
	// Peripheral windows decoded for the fault check
	localparam logic [11:0] PERIPH_WDOG = 12'h0000;
	localparam logic [11:0] PERIPH_SAMPLER = 12'h0038;
	localparam logic [11:0] PERIPH_CAN = 12'h0040;
	localparam logic [11:0] PERIPH_KEEPER = 12'h00FC;
	// Power states
	typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DEEP} rmcg_pwr_t;
endpackage

// ### rmcg_gate.sv
/*
 Run-mode clock gating control: one AHB-Lite slave holding the run, sleep and
 deep-sleep gating registers plus the auto-gating select, driving per-unit clock
 enables and a fault check for peripheral accesses. Assumes a single master,
 single word transfers, and that the glitch-free clock gate cells live next to
 each peripheral and take the registered enables below.
*/
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - each enable bit drives one unit clock enable; set clocks it, clear stops it
// - any access to a unit whose enable is clear raises a bus fault
// - all gating bits reset to zero except those documented otherwise
// - bit 24 read/write gates the controller-area unit, reset zero
// - bit 16 read/write gates the sampler, reset zero; gated access faults
// - bits 9:8 select sampler rate 125K, 250K or 500K samples per second
// - bit 6 gates the sleep keeper and resets to one
// - bit 3 gates the watchdog, reset zero; gated access faults
// - reserved bits read zero and ignore writes
// - run register governs running and the sampler rate in all states; sleep and deep registers govern low-power enables
// - sleep and deep registers apply only while auto gating is selected
module rmcg_gate (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Power state request from the power manager
	input wire logic sleepReq,
	input wire logic deepSleepReq,
	// Peripheral access monitor
	input wire logic periphAccess,
	input wire logic [11:0] periphAddr,
	// Unit clock enables, sampler rate and bus fault
	output logic canClkEn,
	output logic samplerClkEn,
	output logic keeperClkEn,
	output logic wdogClkEn,
	output logic [1:0] sampleRateLimit,
	output logic busFault
);
	import rmcg_pkg::*;

	logic [31:0] runGate_ff;
	logic [31:0] sleepGate_ff;
	logic [31:0] deepGate_ff;
	logic [31:0] runConfig_ff;
	logic wrPend_ff;
	logic [11:0] wrAddr_ff;
	logic [31:0] activeGate;
	logic [31:0] nxt_rdata;
	logic addrPhase;
	logic nxt_fault;
	rmcg_pwr_t pwrState;

	// Address decode shared by the read path and the write register
	function automatic logic [1:0] reg_sel(input logic [11:0] a);
		unique case (a)
			RUN_GATE_OFF: reg_sel = 2'h0;
			SLEEP_GATE_OFF: reg_sel = 2'h1;
			DEEP_GATE_OFF: reg_sel = 2'h2;
			default: reg_sel = 2'h3;
		endcase
	endfunction

	assign addrPhase = hsel && hready && htrans[1];

	// Capture the address phase of a write; data follows one cycle later
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 12'h000;
		end
		else
		begin
			wrPend_ff <= addrPhase && hwrite;
			wrAddr_ff <= haddr[11:0];
		end
	end

	// Gating registers; only documented bits accept writes so reserved ones stay zero
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			runGate_ff <= GATE_RESET;
			sleepGate_ff <= GATE_RESET;
			deepGate_ff <= GATE_RESET;
			runConfig_ff <= CONFIG_RESET;
		end
		else if (wrPend_ff)
		begin
			if (wrAddr_ff == RUN_CONFIG_OFF)
				runConfig_ff <= hwdata & CONFIG_WMASK;
			else
			begin
				unique case (reg_sel(wrAddr_ff))
					2'h0: runGate_ff <= hwdata & GATE_WMASK;
					2'h1: sleepGate_ff <= hwdata & GATE_WMASK;
					2'h2: deepGate_ff <= hwdata & GATE_WMASK;
					default: ;
				endcase
			end
		end
	end

	// Pick the gating set for the current power state
	always_comb
	begin
		pwrState = PWR_RUN;
		if (runConfig_ff[AUTO_GATE_BIT] && deepSleepReq)
			pwrState = PWR_DEEP;
		else if (runConfig_ff[AUTO_GATE_BIT] && sleepReq)
			pwrState = PWR_SLEEP;
		unique case (pwrState)
			PWR_SLEEP: activeGate = sleepGate_ff;
			PWR_DEEP: activeGate = deepGate_ff;
			default: activeGate = runGate_ff;
		endcase
	end

	// Registered enables: stable for a whole cycle so the gate cells never glitch
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			canClkEn <= GATE_RESET[CAN_BIT];
			samplerClkEn <= GATE_RESET[SAMPLER_BIT];
			keeperClkEn <= GATE_RESET[KEEPER_BIT];
			wdogClkEn <= GATE_RESET[WDOG_BIT];
			sampleRateLimit <= GATE_RESET[RATE_MSB:RATE_LSB];
		end
		else
		begin
			canClkEn <= activeGate[CAN_BIT];
			samplerClkEn <= activeGate[SAMPLER_BIT];
			keeperClkEn <= activeGate[KEEPER_BIT];
			wdogClkEn <= activeGate[WDOG_BIT];
			sampleRateLimit <= runGate_ff[RATE_MSB:RATE_LSB];
		end
	end

	// Fault on access to a unit whose clock is off
	always_comb
	begin
		nxt_fault = 1'b0;
		if (periphAccess)
		begin
			unique case (periphAddr)
				PERIPH_WDOG: nxt_fault = !activeGate[WDOG_BIT];
				PERIPH_SAMPLER: nxt_fault = !activeGate[SAMPLER_BIT];
				PERIPH_CAN: nxt_fault = !activeGate[CAN_BIT];
				PERIPH_KEEPER: nxt_fault = !activeGate[KEEPER_BIT];
				default: nxt_fault = 1'b0;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			busFault <= 1'b0;
		else
			busFault <= nxt_fault;
	end

	// Read mux; unmapped words read zero
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (haddr[11:0] == RUN_CONFIG_OFF)
			nxt_rdata = runConfig_ff;
		else
		begin
			unique case (reg_sel(haddr[11:0]))
				2'h0: nxt_rdata = runGate_ff;
				2'h1: nxt_rdata = sleepGate_ff;
				2'h2: nxt_rdata = deepGate_ff;
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Zero wait states; response is always OKAY
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hrdata <= (addrPhase && !hwrite) ? nxt_rdata : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Checks
	property p_reset_keeper;
		@(posedge core_clk) $fell(reset) |-> keeperClkEn && !wdogClkEn && !canClkEn;
	endproperty
	a_reset_keeper: assert property (p_reset_keeper) else $error("reset enables wrong");

	property p_can_follows;
		@(posedge core_clk) disable iff (reset)
			!runConfig_ff[AUTO_GATE_BIT] |=> canClkEn == $past(runGate_ff[CAN_BIT]);
	endproperty
	a_can_follows: assert property (p_can_follows) else $error("can enable stale");

	property p_sampler_follows;
		@(posedge core_clk) disable iff (reset)
			!runConfig_ff[AUTO_GATE_BIT] |=> samplerClkEn == $past(runGate_ff[SAMPLER_BIT]);
	endproperty
	a_sampler_follows: assert property (p_sampler_follows) else $error("sampler stale");

	property p_wdog_write;
		@(posedge core_clk) disable iff (reset)
			wrPend_ff && wrAddr_ff == RUN_GATE_OFF && !runConfig_ff[AUTO_GATE_BIT]
			|=> ##1 wdogClkEn == $past(hwdata[WDOG_BIT], 2);
	endproperty
	a_wdog_write: assert property (p_wdog_write) else $error("watchdog write lost");

	property p_rate;
		@(posedge core_clk) disable iff (reset)
			wrPend_ff && wrAddr_ff == RUN_GATE_OFF
			|=> ##1 sampleRateLimit == $past(hwdata[RATE_MSB:RATE_LSB], 2);
	endproperty
	a_rate: assert property (p_rate) else $error("rate field wrong");

	property p_reserved;
		@(posedge core_clk) disable iff (reset) (runGate_ff & ~GATE_WMASK) == 32'h0000_0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	property p_fault;
		@(posedge core_clk) disable iff (reset)
			periphAccess && periphAddr == PERIPH_WDOG && !activeGate[WDOG_BIT] |=> busFault;
	endproperty
	a_fault: assert property (p_fault) else $error("missing bus fault");

	property p_no_fault;
		@(posedge core_clk) disable iff (reset) !periphAccess |=> !busFault;
	endproperty
	a_no_fault: assert property (p_no_fault) else $error("spurious fault");

	property p_auto_off;
		@(posedge core_clk) disable iff (reset)
			!runConfig_ff[AUTO_GATE_BIT] && sleepReq |=> keeperClkEn == $past(runGate_ff[KEEPER_BIT]);
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("sleep set used early");

	property p_keeper_follows;
		@(posedge core_clk) disable iff (reset)
			!runConfig_ff[AUTO_GATE_BIT] |=> keeperClkEn == $past(runGate_ff[KEEPER_BIT]);
	endproperty
	a_keeper_follows: assert property (p_keeper_follows) else $error("keeper stale");

	property p_wdog_follows;
		@(posedge core_clk) disable iff (reset)
			!runConfig_ff[AUTO_GATE_BIT] |=> wdogClkEn == $past(runGate_ff[WDOG_BIT]);
	endproperty
	a_wdog_follows: assert property (p_wdog_follows) else $error("watchdog stale");

	// Sleep set only while no deep request is up, since deep wins
	property p_sleep_set;
		@(posedge core_clk) disable iff (reset)
			runConfig_ff[AUTO_GATE_BIT] && sleepReq && !deepSleepReq
			|=> canClkEn == $past(sleepGate_ff[CAN_BIT]);
	endproperty
	a_sleep_set: assert property (p_sleep_set) else $error("sleep set not used");

	property p_deep_set;
		@(posedge core_clk) disable iff (reset)
			runConfig_ff[AUTO_GATE_BIT] && deepSleepReq
			|=> samplerClkEn == $past(deepGate_ff[SAMPLER_BIT]);
	endproperty
	a_deep_set: assert property (p_deep_set) else $error("deep set not used");

	property p_fault_sampler;
		@(posedge core_clk) disable iff (reset)
			periphAccess && periphAddr == PERIPH_SAMPLER && !activeGate[SAMPLER_BIT] |=> busFault;
	endproperty
	a_fault_sampler: assert property (p_fault_sampler) else $error("sampler fault lost");

	property p_fault_can;
		@(posedge core_clk) disable iff (reset)
			periphAccess && periphAddr == PERIPH_CAN && !activeGate[CAN_BIT] |=> busFault;
	endproperty
	a_fault_can: assert property (p_fault_can) else $error("can fault lost");

	property p_fault_keeper;
		@(posedge core_clk) disable iff (reset)
			periphAccess && periphAddr == PERIPH_KEEPER && !activeGate[KEEPER_BIT] |=> busFault;
	endproperty
	a_fault_keeper: assert property (p_fault_keeper) else $error("keeper fault lost");

	// A fault pulse always traces back to an access one cycle earlier
	property p_fault_cause;
		@(posedge core_clk) disable iff (reset) busFault |-> $past(periphAccess);
	endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("fault without access");

	property p_read_idle;
		@(posedge core_clk) disable iff (reset)
			!(addrPhase && !hwrite) |=> hrdata == 32'h0000_0000;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data outside phase");

	property p_read_run;
		@(posedge core_clk) disable iff (reset)
			addrPhase && !hwrite && haddr[11:0] == RUN_GATE_OFF |=> hrdata == $past(runGate_ff);
	endproperty
	a_read_run: assert property (p_read_run) else $error("run register read wrong");

	property p_reserved_low;
		@(posedge core_clk) disable iff (reset)
			((sleepGate_ff | deepGate_ff) & ~GATE_WMASK) == 32'h0000_0000;
	endproperty
	a_reserved_low: assert property (p_reserved_low) else $error("low power reserved set");

	property p_config_mask;
		@(posedge core_clk) disable iff (reset) (runConfig_ff & ~CONFIG_WMASK) == 32'h0000_0000;
	endproperty
	a_config_mask: assert property (p_config_mask) else $error("config reserved set");

	// The run set only moves on a write, so enables never change on their own while auto gating is off
	property p_run_hold;
		@(posedge core_clk) disable iff (reset)
			!wrPend_ff |=> runGate_ff == $past(runGate_ff);
	endproperty
	a_run_hold: assert property (p_run_hold) else $error("run set changed unasked");

	c_write: cover property (@(posedge core_clk) wrPend_ff && wrAddr_ff == RUN_GATE_OFF);
	c_fault: cover property (@(posedge core_clk) busFault);
	c_sleep: cover property (@(posedge core_clk) pwrState == PWR_SLEEP);
	c_deep: cover property (@(posedge core_clk) pwrState == PWR_DEEP);
endmodule
`default_nettype wire

// ### tb_top.sv
/*
 Self-checking bench for rmcg_gate: AHB-Lite register traffic, power state
 requests and peripheral access pokes. Assumes zero wait states as handed over.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import rmcg_pkg::*;
	// Rate values 2 and 3 stay out of random data (bit 9 cleared), software never writes 3
	localparam logic [31:0] SAFE = 32'hFFFF_FDFF;
	localparam logic [11:0] WIN [4] = '{PERIPH_CAN, PERIPH_SAMPLER, PERIPH_KEEPER, PERIPH_WDOG};
	logic core_clk, reset, hsel, hwrite, hreadyout, hresp, sleepReq, deepSleepReq;
	logic periphAccess, canClkEn, samplerClkEn, keeperClkEn, wdogClkEn, busFault;
	logic [1:0] htrans, sampleRateLimit;
	logic [2:0] hsize;
	logic [11:0] periphAddr;
	logic [31:0] haddr, hwdata, hrdata, rd, seed, runVal, lowVal;
	logic [5:0] pins;
	int errTotal, comparisons;
	wire logic hready = hreadyout; // One slave: its ready is the bus ready
	assign pins = {canClkEn, samplerClkEn, keeperClkEn, wdogClkEn, sampleRateLimit};

	rmcg_gate dut (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleepReq(sleepReq),
		.deepSleepReq(deepSleepReq), .periphAccess(periphAccess), .periphAddr(periphAddr),
		.canClkEn(canClkEn), .samplerClkEn(samplerClkEn), .keeperClkEn(keeperClkEn),
		.wdogClkEn(wdogClkEn), .sampleRateLimit(sampleRateLimit), .busFault(busFault));

	// Free-running 100 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
	endfunction

	// Pin image expected from a gating register value
	function automatic logic [5:0] expPins(input logic [31:0] v);
		return {v[CAN_BIT], v[SAMPLER_BIT], v[KEEPER_BIT], v[WDOG_BIT], v[RATE_MSB:RATE_LSB]};
	endfunction

	task automatic chkWord(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chkPin(input string nm, input logic [5:0] e, input logic [5:0] g);
		comparisons++;
		if (g !== e)
		begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Bounded wait for ready; a hung slave ends the run
	task automatic waitRdy();
		int n;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (hready !== 1'b1 && n < 16);
		if (hready !== 1'b1)
		begin
			errTotal++;
			results();
		end
	endtask

	// Single word transfer; entered and left just after a rising edge
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		waitRdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		waitRdy();
		rd = hrdata;
		chkPin("resp", 6'h02, {4'h0, hreadyout, hresp});
	endtask

	// One-cycle access to a unit window; fault only while its clock is off
	task automatic poke(input logic [11:0] w, input logic en);
		periphAccess <= 1'b1;
		periphAddr <= w;
		@(posedge core_clk);
		periphAccess <= 1'b0;
		@(negedge core_clk);
		chkPin("busFault", {5'h00, ~en}, {5'h00, busFault});
		@(posedge core_clk);
	endtask

	// Enables land one edge after the write, so two falling edges suffice
	task automatic settle(input string nm, input logic [31:0] v);
		repeat (2) @(negedge core_clk);
		chkPin(nm, expPins(v), pins);
		@(posedge core_clk);
	endtask

	// Main sequence
	initial
	begin
		reset = 1'b1;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		sleepReq = 1'b0;
		deepSleepReq = 1'b0;
		periphAccess = 1'b0;
		periphAddr = '0;
		seed = 32'h0000_001B;
		errTotal = 0;
		comparisons = 0;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		chkPin("resetPins", 6'h08, pins);
		bus(1'b0, RUN_GATE_OFF, '0);
		chkWord("runReset", GATE_RESET, rd);
		for (int i = 0; i < 24; i++)
		begin
			seed = lfsr(seed);
			runVal = seed & SAFE;
			if (i < 3)
				runVal[RATE_MSB:RATE_LSB] = i[1:0];
			if (i == 3)
				runVal = SAFE;
			if (i == 4)
				runVal = '0;
			bus(1'b1, RUN_GATE_OFF, runVal);
			settle("enables", runVal);
			bus(1'b0, RUN_GATE_OFF, '0);
			chkWord("runRead", runVal & GATE_WMASK, rd);
			for (int k = 0; k < 4; k++)
				poke(WIN[k], expPins(runVal)[5 - k]);
		end
		// Unmapped place reads zero and keeps nothing
		bus(1'b1, 32'h0000_0200, 32'hFFFF_FFFF);
		bus(1'b0, 32'h0000_0200, '0);
		chkWord("unmapped", 32'h0000_0000, rd);
		// Low-power registers only count once auto gating is selected
		lowVal = lfsr(seed) & SAFE;
		bus(1'b1, SLEEP_GATE_OFF, lowVal);
		bus(1'b1, DEEP_GATE_OFF, ~lowVal & SAFE);
		sleepReq <= 1'b1;
		settle("sleepNoAuto", runVal);
		bus(1'b1, RUN_CONFIG_OFF, CONFIG_WMASK);
		// Rate pins always follow the run register, whatever set is active
		settle("sleepAuto", (lowVal & ~32'h0000_0300) | (runVal & 32'h0000_0300));
		deepSleepReq <= 1'b1;
		settle("deepAuto", (~lowVal & SAFE & ~32'h0000_0300) | (runVal & 32'h0000_0300));
		results();
	end
endmodule
`default_nettype wire
